//--- mor_pkg.sv
// Shared constants and types for the muting override block.
`default_nettype none
package mor_pkg;

  // Logic clock rate and the time figures derived from it.
  localparam int CLK_HZ        = 100_000_000;
  localparam int SEC_UNIT_S    = 1;
  localparam int SEC_CYCLES    = CLK_HZ * SEC_UNIT_S;
  localparam int TIMEOUT_MIN_S = 10;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_TIMEOUT  = 8'h04;
  localparam logic [7:0] ADR_STATUS   = 8'h08;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h10;

  // Widths of the configuration fields.
  localparam int CTRL_W    = 6;
  localparam int TIMEOUT_W = 16;
  localparam int IRQ_W     = 3;

  // Reset values: occupied-sensor option on, limit of ten seconds.
  localparam logic [CTRL_W-1:0]    CTRL_RST          = 6'h02;
  localparam logic [TIMEOUT_W-1:0] TIMEOUT_RST       = 16'h000A;
  localparam logic [TIMEOUT_W-1:0] TIMEOUT_UNLIMITED = 16'h0000;
  localparam logic [TIMEOUT_W-1:0] TIMEOUT_MIN       = 16'h000A;
  localparam logic [IRQ_W-1:0]     IRQ_MASK_RST      = 3'h0;

  // Configuration bits held in the control register, bit 0 last.
  typedef struct packed {
    logic reset_monitored;
    logic with_reset;
    logic with_request;
    logic with_active_out;
    logic with_occupied;
    logic edge_mode;
  } mor_ctrl_t;

  // Event bits shared by the sticky status and the mask register.
  typedef struct packed {
    logic timeout_end;
    logic clear_end;
    logic start;
  } mor_irq_t;

  // Override sequencer states.
  typedef enum logic {
    MOR_IDLE,
    MOR_ACTIVE
  } mor_state_t;

endpackage
`default_nettype wire

//--- mor_reset_detect.sv
// Recognises a reset command on the reset input, manual or monitored.
`timescale 1ns/100ps
`default_nettype none
module mor_reset_detect (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  input  wire logic monitored_i,
  output logic      pulse_o
);

  typedef struct packed {
    logic prev;
    logic seen_rise;
    logic pulse;
  } mor_rdet_t;

  mor_rdet_t q;
  mor_rdet_t next_q;

  // Edge tracking and the one-cycle recognition pulse.
  always_comb begin
    next_q       = q;
    next_q.prev  = level_i;
    next_q.pulse = 1'b0;
    if (!monitored_i) begin
      next_q.pulse     = level_i & ~q.prev;
      next_q.seen_rise = 1'b0;
    end else begin
      if (level_i & ~q.prev) begin
        next_q.seen_rise = 1'b1;
      end else if (~level_i & q.prev & q.seen_rise) begin
        next_q.pulse     = 1'b1;
        next_q.seen_rise = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign pulse_o = q.pulse;

endmodule
`default_nettype wire

//--- mor_override.sv
// Muting override function block with a Wishbone register slave.
//
// Overview of operation
// - Accept override only unmuted with occupancy.
// - Accepted override drives safety output high.
// - End override when grid and sensors clear.
// - Start by level or by rising edge.
// - Level start needs command low then high.
// - Level start ends itself on clear/timeout.
// - Edge start begins on command rising edge.
// - Edge restart needs command asserted again.
// - Time limit ten seconds to unlimited.
// - Optional active-high override-in-progress output.
// - Optional active-high request output when startable.
// - Reset input gates safety output enable.
// - Manual reset is a rising transition.
// - Monitored reset is rise then fall.
`timescale 1ns/100ps
`default_nettype none
module mor_override #(
  parameter int N_SENSORS     = 4,
  parameter int TICKS_PER_SEC = mor_pkg::SEC_CYCLES
) (
  input  wire logic                 SYS_CLK_I,
  input  wire logic                 RST_I,
  input  wire logic                 CYC_I,
  input  wire logic                 STB_I,
  input  wire logic                 WE_I,
  input  wire logic [7:0]           ADR_I,
  input  wire logic [31:0]          DAT_I,
  input  wire logic [3:0]           SEL_I,
  output logic      [31:0]          DAT_O,
  output logic                      ACK_O,
  input  wire logic                 MUTING_I,
  input  wire logic [N_SENSORS-1:0] SENSOR_OCC_I,
  input  wire logic                 GRID_OCC_I,
  input  wire logic                 OVERRIDE_CMD_I,
  input  wire logic                 RESET_IN_I,
  output logic                      SAFETY_O,
  output logic                      OVERRIDE_ACTIVE_OUTPUT_O,
  output logic                      REQUEST_O,
  output logic                      IRQ_O
);

  localparam logic [31:0] TICK_LAST = 32'(TICKS_PER_SEC - 1);

  // Every flip-flop of the block except those in the reset detector.
  typedef struct packed {
    mor_pkg::mor_state_t                  state;
    logic                                 cmd_prev;
    logic                                 cmd_armed;
    logic                                 reset_gate;
    logic [31:0]                          prescale;
    logic [mor_pkg::TIMEOUT_W-1:0]        seconds;
    mor_pkg::mor_ctrl_t                   ctrl;
    logic [mor_pkg::TIMEOUT_W-1:0]        timeout;
    mor_pkg::mor_irq_t                    irq_stat;
    mor_pkg::mor_irq_t                    irq_mask;
    logic                                 ack;
    logic [31:0]                          rdata;
    logic                                 safety;
    logic                                 active_out;
    logic                                 request;
    logic                                 irq;
  } mor_regs_t;

  mor_regs_t q;
  mor_regs_t next_q;

  logic reset_pulse;

  // Merges write data into an old word under the byte enables.
  function automatic logic [31:0] byte_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address match for one register word.
  function automatic logic adr_hit(input logic [7:0] adr,
                                   input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction

  // True while the sequencer holds an override; several outputs decode it.
  function automatic logic in_override(input mor_pkg::mor_state_t st);
    return st == mor_pkg::MOR_ACTIVE;
  endfunction

  // Reset command recognition, manual or monitored.
  // The detector runs in every state; only an active override listens to it.
  mor_reset_detect u_reset_detect (
    .clk_i       (SYS_CLK_I),
    .rst_i       (RST_I),
    .level_i     (RESET_IN_I),
    .monitored_i (q.ctrl.reset_monitored),
    .pulse_o     (reset_pulse)
  );

  logic                          occ_any;
  logic                          occ_start;
  logic                          start_cond;
  logic                          cmd_rise;
  logic                          start_ok;
  logic                          timed_out;
  logic                          bus_go;
  logic                          wr_go;
  logic                          rd_go;
  logic [31:0]                   merged;
  logic [mor_pkg::TIMEOUT_W-1:0] new_limit;
  logic [31:0]                   status_w;
  mor_pkg::mor_irq_t             events;
  mor_pkg::mor_irq_t             rd_clear;

  // Occupancy, start conditions and limit check.
  // Ending looks at every sensor, but starting counts the sensors only
  // when the occupied option is set.
  always_comb begin
    occ_any   = GRID_OCC_I | (|SENSOR_OCC_I);
    occ_start = GRID_OCC_I | (q.ctrl.with_occupied & (|SENSOR_OCC_I));
    start_cond = ~MUTING_I & occ_start;
    cmd_rise   = OVERRIDE_CMD_I & ~q.cmd_prev;
    if (q.ctrl.edge_mode) begin
      // Restart needs new assertion.
      // The edge is taken against the level sampled one cycle ago, so a
      // command already high when an override ends cannot restart it.
      start_ok = start_cond & cmd_rise;
    end else begin
      start_ok = start_cond & OVERRIDE_CMD_I & q.cmd_armed;
    end
    timed_out = (q.timeout != mor_pkg::TIMEOUT_UNLIMITED) && (q.seconds >= q.timeout);
  end

  // Bus decode and the readable status word.
  // An access is taken only while the previous acknowledge is low, so a
  // master that holds its strobe a cycle too long is not served twice.
  always_comb begin
    bus_go   = CYC_I & STB_I & ~q.ack;
    wr_go    = bus_go & WE_I;
    rd_go    = bus_go & ~WE_I;
    status_w = {q.seconds, 11'h000, q.cmd_armed, q.reset_gate,
                start_cond, q.safety, in_override(q.state)};
  end

  // Next-state logic for the sequencer, the registers and the outputs.
  always_comb begin
    next_q          = q;
    events          = '0;
    rd_clear        = '0;
    merged          = 32'h00000000;
    new_limit       = q.timeout;
    next_q.cmd_prev = OVERRIDE_CMD_I;

    // Command low re-arms.
    // The arm flag starts cleared, so a command held high through reset
    // cannot start a level-mode override until it has been seen low once.
    if (!OVERRIDE_CMD_I) begin
      next_q.cmd_armed = 1'b1;
    end

    case (q.state)
      mor_pkg::MOR_IDLE: begin
        if (start_ok) begin
          next_q.state      = mor_pkg::MOR_ACTIVE;
          next_q.cmd_armed  = 1'b0;
          next_q.reset_gate = 1'b0;
          next_q.prescale   = 32'h00000000;
          next_q.seconds    = '0;
          events.start      = 1'b1;
        end
      end
      mor_pkg::MOR_ACTIVE: begin
        // Advance limit counter.
        // The seconds count saturates instead of wrapping, so a very long
        // unlimited override never looks freshly started.
        if (q.prescale == TICK_LAST) begin
          next_q.prescale = 32'h00000000;
          if (q.seconds != '1) begin
            next_q.seconds = q.seconds + 1'b1;
          end
        end else begin
          next_q.prescale = q.prescale + 32'h00000001;
        end
        if (reset_pulse) begin
          next_q.reset_gate = 1'b1;
        end
        // Ends itself without command.
        // Dropping the command is ignored here; only a clear opening or the
        // limit ends an override, whatever the start method.
        if (!occ_any) begin
          next_q.state     = mor_pkg::MOR_IDLE;
          events.clear_end = 1'b1;
        end else if (timed_out) begin
          next_q.state       = mor_pkg::MOR_IDLE;
          events.timeout_end = 1'b1;
        end
      end
      default: begin
        next_q.state = mor_pkg::MOR_IDLE;
      end
    endcase

    // Register writes take effect on the acknowledged cycle.
    next_q.ack = bus_go;
    if (wr_go) begin
      if (adr_hit(ADR_I, mor_pkg::ADR_CTRL)) begin
        merged      = byte_merge(32'(q.ctrl), DAT_I, SEL_I);
        next_q.ctrl = mor_pkg::mor_ctrl_t'(merged[mor_pkg::CTRL_W-1:0]);
      end
      if (adr_hit(ADR_I, mor_pkg::ADR_TIMEOUT)) begin
        merged    = byte_merge(32'(q.timeout), DAT_I, SEL_I);
        new_limit = merged[mor_pkg::TIMEOUT_W-1:0];
        // Zero keeps its meaning of no limit; any other value below the
        // minimum is raised to it rather than refused.
        // Finite limit at least ten.
        if (new_limit != mor_pkg::TIMEOUT_UNLIMITED && new_limit < mor_pkg::TIMEOUT_MIN) begin
          new_limit = mor_pkg::TIMEOUT_MIN;
        end
        next_q.timeout = new_limit;
      end
      if (adr_hit(ADR_I, mor_pkg::ADR_IRQ_MASK)) begin
        merged          = byte_merge(32'(q.irq_mask), DAT_I, SEL_I);
        next_q.irq_mask = mor_pkg::mor_irq_t'(merged[mor_pkg::IRQ_W-1:0]);
      end
    end

    // Read data; unmapped words read as zero.
    // Reading the event word clears exactly the bits it returns, so an event
    // that lands between the read and the clear is never lost.
    next_q.rdata = 32'h00000000;
    if (rd_go) begin
      if (adr_hit(ADR_I, mor_pkg::ADR_CTRL)) begin
        next_q.rdata = 32'(q.ctrl);
      end else if (adr_hit(ADR_I, mor_pkg::ADR_TIMEOUT)) begin
        next_q.rdata = 32'(q.timeout);
      end else if (adr_hit(ADR_I, mor_pkg::ADR_STATUS)) begin
        next_q.rdata = status_w;
      end else if (adr_hit(ADR_I, mor_pkg::ADR_IRQ_STAT)) begin
        next_q.rdata = 32'(q.irq_stat);
        rd_clear     = q.irq_stat;
      end else if (adr_hit(ADR_I, mor_pkg::ADR_IRQ_MASK)) begin
        next_q.rdata = 32'(q.irq_mask);
      end
    end

    // Sticky events; a new event wins over the read clear.
    // The interrupt is registered from the next status, so it moves with it.
    next_q.irq_stat = (q.irq_stat & ~rd_clear) | events;
    next_q.irq      = |(next_q.irq_stat & next_q.irq_mask);

    // The gate is cleared at every start, so a reset recognised during an
    // earlier override never carries over to the next one.
    // Gate safety on reset.
    next_q.safety = in_override(next_q.state) &
                    (~q.ctrl.with_reset | next_q.reset_gate);
    next_q.active_out = q.ctrl.with_active_out & in_override(next_q.state);
    next_q.request = q.ctrl.with_request & start_cond;
  end

  // State register.
  // Reset puts the configuration at its defaults and clears everything
  // else, including the arm flag and the sticky events.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      q          <= '0;
      q.state    <= mor_pkg::MOR_IDLE;
      q.ctrl     <= mor_pkg::mor_ctrl_t'(mor_pkg::CTRL_RST);
      q.timeout  <= mor_pkg::TIMEOUT_RST;
      q.irq_mask <= mor_pkg::mor_irq_t'(mor_pkg::IRQ_MASK_RST);
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from the state register.
  // No logic sits between a flip-flop and a pin, so outputs cannot glitch.
  assign DAT_O                    = q.rdata;
  assign ACK_O                    = q.ack;
  assign SAFETY_O                 = q.safety;
  assign OVERRIDE_ACTIVE_OUTPUT_O = q.active_out;
  assign REQUEST_O                = q.request;
  assign IRQ_O                    = q.irq;

endmodule
`default_nettype wire

//--- mor_override_monitor.sv
// Checker of the override block's port behaviour.
`timescale 1ns/100ps
`default_nettype none
module mor_override_monitor #(
  parameter int N_SENSORS = 4
) (
  input wire logic                 SYS_CLK_I,
  input wire logic                 RST_I,
  input wire logic                 CYC_I,
  input wire logic                 STB_I,
  input wire logic [31:0]          DAT_O,
  input wire logic                 ACK_O,
  input wire logic                 MUTING_I,
  input wire logic [N_SENSORS-1:0] SENSOR_OCC_I,
  input wire logic                 GRID_OCC_I,
  input wire logic                 OVERRIDE_CMD_I,
  input wire logic                 SAFETY_O,
  input wire logic                 OVERRIDE_ACTIVE_OUTPUT_O,
  input wire logic                 REQUEST_O
);
  logic occ;

  // Any occupancy seen by the sensors or the light grid.
  assign occ = (|SENSOR_OCC_I) || GRID_OCC_I;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  // Bus answers arrive one cycle after the request and last one cycle.
  a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("bus request not answered");
  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("acknowledge held too long");
  a_data_quiet: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("read data outside acknowledge");
  // Overrides start only unmuted, occupied and commanded.
  a_start_unmuted: assert property ($rose(OVERRIDE_ACTIVE_OUTPUT_O) |->
    $past(!MUTING_I && occ)) else $error("override started while muted or clear");
  a_start_command: assert property ($rose(OVERRIDE_ACTIVE_OUTPUT_O) |->
    $past(OVERRIDE_CMD_I)) else $error("override started without command");
  // A clear opening ends the override on the next cycle.
  a_clear_ends: assert property (OVERRIDE_ACTIVE_OUTPUT_O && !occ |=>
    !OVERRIDE_ACTIVE_OUTPUT_O) else $error("override outlived clear opening");
  a_clear_safety: assert property (SAFETY_O && !occ |=> !SAFETY_O)
    else $error("safety output outlived clear opening");
  a_request_cond: assert property (REQUEST_O |->
    $past(!MUTING_I && occ)) else $error("request without start conditions");
endmodule
`default_nettype wire

bind mor_override mor_override_monitor #(.N_SENSORS(N_SENSORS)) u_mon (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .DAT_O(DAT_O), .ACK_O(ACK_O), .MUTING_I(MUTING_I), .SENSOR_OCC_I(SENSOR_OCC_I),
  .GRID_OCC_I(GRID_OCC_I), .OVERRIDE_CMD_I(OVERRIDE_CMD_I), .SAFETY_O(SAFETY_O),
  .OVERRIDE_ACTIVE_OUTPUT_O(OVERRIDE_ACTIVE_OUTPUT_O), .REQUEST_O(REQUEST_O));

//--- mor_far_model.sv
// Model of the muting stage and sensors ahead of the override block.
`timescale 1ns/100ps
`default_nettype none
module mor_far_model (
  input  wire logic       clk_i,
  input  wire logic [5:0] want_i,
  output logic            muting_o,
  output logic [3:0]      sensor_o,
  output logic            grid_o
);
  // muting registered from want_i
  // The stage output and the sensors change just after a clock edge.
  always_ff @(posedge clk_i) begin
    {muting_o, sensor_o, grid_o} <= want_i;
  end
endmodule
`default_nettype wire

//--- test_mor_override.sv
// Self-checking bench for the muting override block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_mor_override;
  typedef struct packed {
    logic [5:0] ctrl;
    logic [5:0] far;
    logic [2:0] ev;
  } mor_row_t;
  logic        clk, rst, cyc, stb, we, cmd, rin, rq;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [5:0]  want;
  logic [3:0]  sens;
  logic        ack, mute, grid, safety, act, req, irq;
  int          err_total, n_tests;
  mor_row_t    rows [7] = '{'{6'h0E, 6'h02, 3'h7}, '{6'h0E, 6'h22, 3'h0},
    '{6'h0E, 6'h00, 3'h0}, '{6'h0C, 6'h02, 3'h0}, '{6'h0C, 6'h01, 3'h7},
    '{6'h0F, 6'h01, 3'h7}, '{6'h02, 6'h01, 3'h1}};
  logic [7:0]  ra [4] = '{mor_pkg::ADR_CTRL, mor_pkg::ADR_TIMEOUT, mor_pkg::ADR_IRQ_MASK, 8'hFC};
  logic [31:0] rv [4] = '{32'h2, 32'hA, 32'h0, 32'h0};

  mor_override #(.N_SENSORS(4), .TICKS_PER_SEC(10)) uut (
    .SYS_CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .DAT_I(wdat), .SEL_I(4'hF), .DAT_O(rdat), .ACK_O(ack), .MUTING_I(mute),
    .SENSOR_OCC_I(sens), .GRID_OCC_I(grid), .OVERRIDE_CMD_I(cmd), .RESET_IN_I(rin),
    .SAFETY_O(safety), .OVERRIDE_ACTIVE_OUTPUT_O(act), .REQUEST_O(req), .IRQ_O(irq));
  mor_far_model far (.clk_i(clk), .want_i(want), .muting_o(mute), .sensor_o(sens),
    .grid_o(grid));

  // Free-running logic clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One classic bus cycle; read data lands in q at the acknowledging edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask

  // Configures, sets the opening, notes the request, then raises the command.
  task automatic go(input logic [5:0] c, input logic [5:0] f);
    wb(1'b1, mor_pkg::ADR_CTRL, {26'h0, c});
    want <= f;
    cmd <= 1'b0;
    tick(4);
    rq = req;
    cmd <= 1'b1;
    tick(3);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cuts a hung run short long after the tests should have ended.
  initial begin
    #500000;
    err_total++;
    results();
  end

  // Main sequence: table of ordinary cases, then the awkward ones.
  initial begin
    {cyc, stb, we, cmd, rin, adr, wdat, want} = '0;
    rst = 1'b1;
    err_total = 0;
    n_tests = 0;
    tick(20);
    rst <= 1'b0;
    foreach (rows[i]) begin
      go(rows[i].ctrl, rows[i].far);
      `CHK("request", rows[i].ev[2], rq)
      `CHK("active", rows[i].ev[1], act)
      `CHK("safety", rows[i].ev[0], safety)
      want <= 6'h00;
      tick(4);
      `CHK("ended", 1'b0, safety)
      $display("row %0d done", i);
    end
    for (int i = 0; i < 2; i++) begin
      go({5'h07, i[0]}, 6'h01);
      want <= 6'h00;
      tick(4);
      want <= 6'h01;
      tick(4);
      `CHK("rearm", 1'b0, act)
      cmd <= 1'b0;
      tick(2);
      cmd <= 1'b1;
      tick(4);
      `CHK("restart", 1'b1, act)
      want <= 6'h00;
      tick(4);
    end
    $display("restart test done");
    wb(1'b0, mor_pkg::ADR_IRQ_STAT, 32'h0);
    wb(1'b1, mor_pkg::ADR_TIMEOUT, 32'h5);
    wb(1'b0, mor_pkg::ADR_TIMEOUT, 32'h0);
    `CHK("clamp", 32'h0000000A, q)
    go(6'h06, 6'h01);
    cmd <= 1'b0;
    tick(90);
    `CHK("held", 1'b1, act)
    tick(15);
    `CHK("timeout", 1'b0, act)
    `CHK("irq_masked", 1'b0, irq)
    wb(1'b1, mor_pkg::ADR_IRQ_MASK, 32'h4);
    tick(2);
    `CHK("irq_raised", 1'b1, irq)
    wb(1'b0, mor_pkg::ADR_IRQ_STAT, 32'h0);
    `CHK("irq_stat", 32'h5, q)
    tick(2);
    `CHK("irq_clear", 1'b0, irq)
    wb(1'b1, mor_pkg::ADR_TIMEOUT, 32'h0);
    go(6'h06, 6'h01);
    tick(150);
    `CHK("unlimited", 1'b1, act)
    wb(1'b0, mor_pkg::ADR_STATUS, 32'h0);
    `CHK("status", 32'h000F0007, q)
    want <= 6'h00;
    tick(4);
    $display("timeout test done");
    for (int i = 0; i < 2; i++) begin
      go({i[0], 5'h1E}, 6'h01);
      `CHK("gated", 1'b0, safety)
      rin <= 1'b1;
      tick(4);
      `CHK("manual", !i[0], safety)
      rin <= 1'b0;
      tick(4);
      `CHK("monitored", 1'b1, safety)
      want <= 6'h00;
      tick(4);
    end
    $display("reset input test done");
    go(6'h06, 6'h01);
    `CHK("pre_rst", 1'b1, safety)
    rst <= 1'b1;
    tick(2);
    `CHK("rst_safety", 1'b0, safety)
    rst <= 1'b0;
    foreach (ra[i]) begin
      wb(1'b0, ra[i], 32'h0);
      `CHK("reg_reset", rv[i], q)
    end
    $display("register reset test done");
    results();
  end
endmodule
`default_nettype wire
